// file: pixser_consts.vh
// Purpose: constants for the pixel serializer and palette stage
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef PIXSER_CONSTS_VH
`define PIXSER_CONSTS_VH
// Pixel width select codes
`define PW_1 3'h0
`define PW_2 3'h1
`define PW_4 3'h2
`define PW_8 3'h3
`define PW_16 3'h4
`define PW_24 3'h5
// Display type select codes
`define DT_STN_MONO 2'h0
`define DT_STN_COLOR 2'h1
`define DT_TFT 2'h2
// Byte order select codes
`define BO_LITTLE 1'b0
`define BO_BIG 1'b1
// Palette entry field positions
`define PE_INTENSITY 15
`define PE_BLUE_HI 14
`define PE_GREEN_HI 9
`define PE_RED_HI 4
`define PE_RESET 16'h0000
`define PE_ENTRIES 256
`endif

// file: palette_table.v
// Purpose: 256 x 16 palette storage with a host port and a pixel port
// Assumes: host accesses are full word; upper data bits ignored
// Notes: flip-flop storage, host read data registered, pixel lookup combinational
`timescale 1ns/1ps
`include "pixser_consts.vh"
module palette_table #(
    parameter ENTRIES = `PE_ENTRIES
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Host port
    input wire host_sel,
    input wire host_write,
    input wire [7:0] host_index,
    input wire [31:0] host_wdata,
    output reg [31:0] host_rdata,
    // Pixel lookup port
    input wire [7:0] look_index,
    output wire [15:0] look_entry
);
    reg [15:0] entry [0:ENTRIES-1];
    genvar g;

    // Each entry stores any 16-bit value; only low half of bus is used
    generate
        for (g = 0; g < ENTRIES; g = g + 1) begin : g_entry
            // Own index as an 8-bit constant for the write match
            localparam [7:0] SLOT = g;
            always @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    entry[g] <= `PE_RESET;
                end else if (host_sel && host_write &&
                             host_index == SLOT) begin
                    entry[g] <= host_wdata[15:0]; // see RL9 see RL10
                end
            end
        end
    endgenerate

    // Read back zero-extended, upper half reads as zero
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            host_rdata <= 32'h0000_0000;
        end else if (host_sel && !host_write) begin
            host_rdata <= {16'h0000, entry[host_index]}; // see RL8
        end
    end

    assign look_entry = entry[look_index]; // see RL6
endmodule // palette_table

// file: lcd_pixel_serializer_palette.v
// Purpose: split FIFO words into pixels and map them through the palette
// Assumes: FIFO and downstream stages share sys_clk; config held steady
// Notes: one output per cycle at most; downstream stalls with out_ready
//        mapping follows the config seen when a pixel is emitted
`timescale 1ns/1ps
`include "pixser_consts.vh"
// Function
// RL1: Emit 1..24-bit pixels from whole words
// RL2: Little or big endian order selectable
// RL3: Little endian: first pixel in LSBs
// RL4: Big endian: first pixel in MSBs
// RL5: 24bpp packs four pixels per three words
// RL6: Palletized pixel indexes lookup table
// RL7: Palette use by display type, width
// RL8: Host reads and writes every entry
// RL9: Entry in low 16 bits, word writes
// RL10: 256 entries of any 16-bit value
// RL11: Entry holds intensity, blue, green, red
// RL12: STN mono uses red top four bits
// RL13: STN color uses top four bits each
// RL14: TFT uses all five bits each
// RL15: TFT intensity drives bits 18,10,2
// RL16: TFT palette zeroes bits 17:16,9:8,1:0
// RL17: Display type selects palette behaviour
// RL18: One pixel or three sub-pixels
module lcd_pixel_serializer_palette (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Configuration fields of display_config_word_two
    input wire [2:0] pixel_width_select,
    input wire byte_order_select,
    input wire [1:0] display_type_select,
    // Input FIFO side
    input wire fifo_valid,
    input wire [31:0] fifo_data,
    output reg fifo_pop,
    // Palette host port
    input wire palette_sel,
    input wire palette_write,
    input wire [7:0] palette_index,
    input wire [31:0] palette_wdata,
    output wire [31:0] palette_rdata,
    // Output to dithering and shifter
    input wire out_ready,
    output reg out_valid,
    output reg [23:0] panel_data_bus,
    output reg color_mode
);
    // Up to 64 bits held, so a 24-bit pixel may straddle two words
    reg [63:0] acc; // Bits waiting, next pixel aligned by byte order
    reg [6:0] fill;
    reg [6:0] next_fill;
    reg [63:0] next_acc;
    reg [5:0] width;
    reg [23:0] pix;
    reg palletized;
    reg [7:0] look_index;
    wire [15:0] entry;
    wire take_word;
    wire emit;
    reg [23:0] next_pixel;
    reg next_color;
    // Entry fields, split once so every mode takes its own share
    wire entry_intensity;
    wire [4:0] entry_blue;
    wire [4:0] entry_green;
    wire [4:0] entry_red;

    // Decoded pixel width in bits
    function [5:0] width_bits;
        input [2:0] sel;
        begin
            case (sel)
                `PW_1: width_bits = 6'd1;
                `PW_2: width_bits = 6'd2;
                `PW_4: width_bits = 6'd4;
                `PW_8: width_bits = 6'd8;
                `PW_16: width_bits = 6'd16;
                default: width_bits = 6'd24;
            endcase
        end
    endfunction

    // Palette usage by type and width
    function pal_mode;
        input [1:0] dt;
        input [2:0] pw;
        begin
            if (dt == `DT_STN_MONO) begin
                pal_mode = (pw == `PW_1) || (pw == `PW_2); // see RL7
            end else begin
                pal_mode = (pw <= `PW_8); // see RL7 see RL17
            end
        end
    endfunction

    // Decoded mode, shared by the extractor and the mapper
    always @* begin
        width = width_bits(pixel_width_select); // see RL1
        palletized = pal_mode(display_type_select, pixel_width_select);
        next_color = (display_type_select != `DT_STN_MONO); // see RL18
    end

    // Pixel extraction: little takes low bits, big takes high bits
    always @* begin
        if (byte_order_select == `BO_LITTLE) begin
            pix = acc[23:0] & ((24'h000001 << width) - 24'h000001); // see RL3
        end else begin
            pix = acc[63:40] >> (6'd24 - width); // see RL4
        end
        look_index = pix[7:0];
    end

    // Host port and pixel port share the table; no arbitration needed
    palette_table u_palette (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .host_sel(palette_sel),
        .host_write(palette_write),
        .host_index(palette_index),
        .host_wdata(palette_wdata),
        .host_rdata(palette_rdata),
        .look_index(look_index),
        .look_entry(entry)
    );

    // Entry layout, most significant first: intensity, blue, green, red
    assign entry_intensity = entry[`PE_INTENSITY]; // see RL11
    assign entry_blue = entry[`PE_BLUE_HI -: 5];
    assign entry_green = entry[`PE_GREEN_HI -: 5];
    assign entry_red = entry[`PE_RED_HI -: 5];

    // Emit when a whole pixel is held and the output slot is free
    assign emit = ({1'b0, width} <= fill) && (!out_valid || out_ready);
    // Pop lags the take, so the FIFO head is stale while it stands
    // Load a word whenever room remains; 24bpp spans words, see RL5
    assign take_word = fifo_valid && !fifo_pop &&
                       ((fill - (emit ? {1'b0, width} : 7'd0)) <= 7'd32);

    // Accumulator update: consume then append behind remaining bits
    always @* begin
        next_acc = acc;
        next_fill = fill;
        if (emit) begin
            if (byte_order_select == `BO_LITTLE) begin
                next_acc = next_acc >> width;
            end else begin
                next_acc = next_acc << width;
            end
            next_fill = next_fill - {1'b0, width};
        end
        if (take_word) begin
            if (byte_order_select == `BO_LITTLE) begin
                // New word lands just above the bits still held
                next_acc = next_acc |
                           ({32'h0, fifo_data} << next_fill); // see RL2
            end else begin
                // New word lands just below the bits still held
                next_acc = next_acc |
                           ({fifo_data, 32'h0} >> next_fill); // see RL2
            end
            next_fill = next_fill + 7'd32;
        end
    end

    // Pop pulse lags by one cycle, so word use is gated on !fifo_pop
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc <= 64'h0;
            fill <= 7'h00;
            fifo_pop <= 1'b0;
        end else begin
            acc <= next_acc;
            fill <= next_fill;
            fifo_pop <= take_word;
        end
    end

    // Palette mapping; raw pixels pass right aligned, see RL7
    always @* begin
        next_pixel = pix;
        if (palletized) begin
            case (display_type_select) // see RL17
                `DT_STN_MONO: begin
                    // Top four red bits give sixteen gray shades
                    next_pixel = {20'h00000, entry_red[4:1]}; // see RL12
                end
                `DT_STN_COLOR: begin
                    // Sub-pixels as {blue, green, red} four-bit shades
                    next_pixel = {12'h000, entry_blue[4:1], // see RL13
                        entry_green[4:1], entry_red[4:1]};
                end
                default: begin
                    // TFT: five bits per colour, then intensity, then two zero LSBs
                    next_pixel = {entry_blue, entry_intensity, // see RL14
                        2'b00, entry_green, entry_intensity, // see RL15
                        2'b00, entry_red, entry_intensity, // see RL16
                        2'b00};
                end
            endcase
        end
    end

    // Output register holds a pixel until downstream takes it
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            panel_data_bus <= 24'h000000;
            color_mode <= 1'b0;
        end else begin
            if (emit) begin
                // Config is sampled here, so change it only when idle
                out_valid <= 1'b1;
                color_mode <= next_color;
                panel_data_bus <= next_pixel;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule // lcd_pixel_serializer_palette

// file: pixser_properties.sv
// Purpose: port checks for the pixel serializer and palette
// Assumes: one clock domain, config held while streaming
// Notes: bound to the top module below
`timescale 1ns/1ps
module pixser_properties (
    // Clock, reset and config
    input wire sys_clk,
    input wire reset_n,
    input wire [2:0] pixel_width_select,
    input wire [1:0] display_type_select,
    // Streams and palette port
    input wire fifo_valid,
    input wire fifo_pop,
    input wire palette_sel,
    input wire palette_write,
    input wire [31:0] palette_rdata,
    input wire out_ready,
    input wire out_valid,
    input wire [23:0] panel_data_bus,
    input wire color_mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Mode decode shared by the mapping checks
    wire pal = pixel_width_select <= 3'h3;
    wire [1:0] dt = display_type_select;
    wire ov = out_valid;
    a_pop_spacing: assert property (fifo_pop |=> !fifo_pop)
        else $error("fifo_pop high two cycles running");
    a_pop_cause: assert property (fifo_pop |-> $past(fifo_valid))
        else $error("fifo_pop without a word offered");
    a_out_hold: assert property (ov && !out_ready |=> ov
        && $stable(panel_data_bus)) else $error("stalled pixel changed");
    a_tft_zeros: assert property (ov && dt[1] && pal
        |-> (panel_data_bus & 24'h030303) == 24'h0)
        else $error("unused panel bits not zero");
    a_tft_intens: assert property (ov && dt[1] && pal
        |-> panel_data_bus[18] == panel_data_bus[10]
        && panel_data_bus[10] == panel_data_bus[2])
        else $error("intensity bits differ");
    a_mono_gray: assert property (ov && dt == 2'h0 && pal
        |-> panel_data_bus[23:4] == 20'h0) else $error("mono too wide");
    a_color_gray: assert property (ov && dt == 2'h1 && pal
        |-> panel_data_bus[23:12] == 12'h0) else $error("color too wide");
    a_raw_sixteen: assert property (ov && dt == 2'h1
        && pixel_width_select == 3'h4 |-> panel_data_bus[23:16] == 8'h0)
        else $error("raw pixel not right aligned");
    a_mode_flag: assert property (ov
        |-> color_mode == (dt != 2'h0))
        else $error("color_mode wrong for display type");
    a_rdata_hold: assert property (!(palette_sel && !palette_write)
        |=> $stable(palette_rdata)) else $error("read data moved");
    a_rdata_upper: assert property (palette_rdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    // Main scenarios reached
    c_stall: cover property (ov && !out_ready);
    c_pop: cover property (fifo_pop);
    c_read: cover property (palette_sel && !palette_write);
endmodule // pixser_properties
bind lcd_pixel_serializer_palette pixser_properties i_pixser_properties (
    .sys_clk, .reset_n, .pixel_width_select, .display_type_select,
    .fifo_valid, .fifo_pop, .palette_sel, .palette_write, .palette_rdata,
    .out_ready, .out_valid, .panel_data_bus, .color_mode);

// file: panel_sink.sv
// Purpose: panel-side sink taking pixels from the stage
// Assumes: bench selects pacing with slow
// Notes: slow mode stalls every other cycle
`timescale 1ns/1ps
module panel_sink (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Pacing
    input wire slow,
    output reg out_ready
);
    // Falling-edge pacing keeps clear of the sampling edge
    always @(negedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= slow ? ~out_ready : 1'b1;
        end
    end
endmodule // panel_sink

// file: tb_lcd_pixel_serializer_palette.sv
// Purpose: self-checking bench for the serializer and palette
// Assumes: inputs change at the falling edge
// Notes: expected pixels come from a bench model
`timescale 1ns/1ps
module tb_lcd_pixel_serializer_palette;
    reg sys_clk = 1'b0;
    reg reset_n = 1'b0;
    reg [2:0] pw = 3'h0;
    reg bo = 1'b0;
    reg [1:0] dt = 2'h0;
    reg fifo_valid = 1'b0;
    reg [31:0] fifo_data = 32'h0;
    reg sel = 1'b0;
    reg wr = 1'b0;
    reg [7:0] idx = 8'h0;
    reg [31:0] wdata = 32'h0;
    reg slow = 1'b0;
    wire fifo_pop, out_ready, out_valid, color_mode;
    wire [31:0] rdata;
    wire [23:0] pix;
    reg [15:0] pal [0:255];
    reg [23:0] expq [$];
    reg [95:0] s;
    reg [6:0] npix;
    integer failures = 0;
    integer num_checks = 0;
    integer r, k;
    // Rows {width, order, type, pixels given by three words}
    localparam [116:0] ROWS = {6'h2f, 7'h04, 6'h2a, 7'h04, 6'h26, 7'h06,
        6'h16, 7'h18, 6'h21, 7'h06, 6'h1d, 7'h0c, 6'h10, 7'h18,
        6'h0c, 7'h30, 6'h00, 7'h60};
    localparam [95:0] WORDS = 96'hf06a93c5_2b9fd460_8e3c51a7;
    lcd_pixel_serializer_palette i_lcd_pixel_serializer_palette (
        .sys_clk(sys_clk), .reset_n(reset_n), .pixel_width_select(pw),
        .byte_order_select(bo), .display_type_select(dt),
        .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_pop(fifo_pop),
        .palette_sel(sel), .palette_write(wr), .palette_index(idx),
        .palette_wdata(wdata), .palette_rdata(rdata), .out_ready(out_ready),
        .out_valid(out_valid), .panel_data_bus(pix), .color_mode(color_mode));
    panel_sink i_panel_sink (.sys_clk(sys_clk), .reset_n(reset_n),
        .slow(slow), .out_ready(out_ready));
    always #4 sys_clk = ~sys_clk;
    task check(input [31:0] got, input [31:0] want);
        begin
            num_checks = num_checks + 1;
            if (got !== want) begin
                failures = failures + 1;
                $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks=%0d failures=%0d", num_checks, failures);
            if (failures == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // One host cycle on the palette port; read data is ready on return
    task pal_op(input w, input [7:0] i, input [31:0] d);
        begin
            sel = 1'b1;
            wr = w;
            idx = i;
            wdata = d;
            @(negedge sys_clk);
            sel = 1'b0;
            @(negedge sys_clk);
        end
    endtask
    // Offer one word until the stage pops it
    task feed(input [31:0] w);
        integer t;
        begin
            fifo_valid = 1'b1;
            fifo_data = w;
            @(negedge sys_clk);
            for (t = 0; t < 200 && fifo_pop !== 1'b1; t = t + 1)
                @(negedge sys_clk);
            check(fifo_pop, 1'b1);
        end
    endtask
    // Pixel k of the three-word stream, mapped as the mode asks
    function [23:0] expect_pix(input integer k);
        reg [23:0] p;
        reg [15:0] e;
        integer w;
        begin
            w = (pw > 3'h4) ? 24 : (1 << pw);
            p = bo ? (s >> (96 - (k + 1) * w)) : (s >> (k * w));
            p = p & ((24'h1 << w) - 24'h1);
            e = pal[p[7:0]];
            if (pw <= 3'h3 && (dt != 2'h0 || pw <= 3'h1))
                p = (dt == 2'h0) ? {20'h0, e[4:1]}
                  : (dt == 2'h1) ? {12'h0, e[14:11], e[9:6], e[4:1]}
                  : {e[14:10], e[15], 2'h0, e[9:5], e[15], 2'h0,
                     e[4:0], e[15], 2'h0};
            expect_pix = p;
        end
    endfunction
    // Every taken pixel must be the next one expected
    always @(posedge sys_clk) begin
        if (reset_n && out_valid && out_ready) begin
            check(pix, expq.size() ? expq.pop_front() : 32'hx);
            check(color_mode, dt != 2'h0);
        end
    end
    // Cuts a hang short well beyond the expected run
    initial begin
        #200000;
        failures = failures + 1;
        complete_run;
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        reset_n = 1'b1;
        check({out_valid, fifo_pop, pix}, 32'h0);
        pal_op(1'b0, 8'h0, 32'h0);
        check(rdata, 32'h0);
        for (k = 0; k < 256; k = k + 1) begin
            pal[k] = k * 16'h9d3b ^ 16'h5a5a;
            pal_op(1'b1, k[7:0], {~pal[k], pal[k]});
        end
        for (k = 0; k < 256; k = k + 1) begin
            pal_op(1'b0, k[7:0], 32'h0);
            check(rdata, {16'h0, pal[k]});
        end
        for (r = 0; r < 9; r = r + 1) begin
            {pw, bo, dt, npix} = ROWS[r * 13 +: 13];
            slow = r[0];
            s = bo ? {WORDS[31:0], WORDS[63:32], WORDS[95:64]} : WORDS;
            for (k = 0; k < npix; k = k + 1)
                expq.push_back(expect_pix(k));
            for (k = 0; k < 3; k = k + 1)
                feed(WORDS[k * 32 +: 32]);
            fifo_valid = 1'b0;
            for (k = 0; k < 400 && expq.size() != 0; k = k + 1)
                @(negedge sys_clk);
            check(expq.size(), 32'h0);
        end
        // Reset in mid-stream: outputs and entries clear, then restart
        {pw, bo, dt} = 6'h00;
        slow = 1'b0;
        s = WORDS;
        for (k = 0; k < 32; k = k + 1)
            expq.push_back(expect_pix(k));
        feed(WORDS[31:0]);
        fifo_valid = 1'b0;
        repeat (4) @(negedge sys_clk);
        reset_n = 1'b0;
        @(negedge sys_clk);
        expq.delete();
        check({out_valid, fifo_pop, color_mode, pix}, 32'h0);
        reset_n = 1'b1;
        pal_op(1'b0, 8'hff, 32'h0);
        check(rdata, 32'h0);
        // Stage restarts cleanly with a raw mono stream
        {pw, bo, dt} = 6'h10;
        for (k = 0; k < 8; k = k + 1)
            expq.push_back(expect_pix(k));
        feed(WORDS[31:0]);
        fifo_valid = 1'b0;
        for (k = 0; k < 40 && expq.size() != 0; k = k + 1)
            @(negedge sys_clk);
        check(expq.size(), 32'h0);
        complete_run;
    end
endmodule // tb_lcd_pixel_serializer_palette
